// file: accel_regs_pkg.sv
// Shared offsets, field positions, reset values and timing counts of the output-data block
package accel_regs_pkg;
	// Clock rate of sys_clk
	localparam int CLK_FREQ_MHZ = 10;
	// Register port, axis value and counter widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int AXIS_BITS = 12;
	localparam int CNT_W = 16;
	// Register offsets
	localparam logic [7:0] ADDR_INT_STATUS = 8'h00;
	localparam logic [7:0] ADDR_TEMPERATURE = 8'h01;
	localparam logic [7:0] ADDR_MAG_LOW = 8'h02;
	localparam logic [7:0] ADDR_MAG_HIGH = 8'h03;
	localparam logic [7:0] ADDR_X_LOW = 8'h04;
	localparam logic [7:0] ADDR_X_HIGH = 8'h05;
	localparam logic [7:0] ADDR_Y_LOW = 8'h06;
	localparam logic [7:0] ADDR_Y_HIGH = 8'h07;
	localparam logic [7:0] ADDR_Z_LOW = 8'h08;
	localparam logic [7:0] ADDR_Z_HIGH = 8'h09;
	localparam logic [7:0] ADDR_SENSOR_CONFIG_TWO = 8'h16;
	localparam logic [7:0] ADDR_SENSOR_CONFIG_FOUR = 8'h18;
	localparam logic [7:0] ADDR_SENSOR_CONFIG_FIVE = 8'h19;
	localparam logic [7:0] ADDR_PIN_SELECT = 8'h21;
	// Field positions
	localparam int STATUS_BOOT_BIT = 0;
	localparam int STATUS_DRDY_BIT = 7;
	localparam int CFG2_ENDIAN_BIT = 0;
	localparam int CFG2_FAST_READ_BIT = 1;
	localparam int CFG4_POLARITY_BIT = 0;
	localparam int CFG4_DRIVER_BIT = 1;
	localparam int CFG5_MAG_EN_BIT = 0;
	localparam int PINSEL_BOOT_ROUTE_BIT = 0;
	// Reset values
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [11:0] OUT_RESET = 12'h000;
	localparam logic [7:0] TEMP_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	// Acquisition channels in order
	localparam logic [1:0] CHAN_TEMP = 2'h0;
	localparam logic [1:0] CHAN_Z = 2'h3;
	// Times in their own units
	localparam int BOOT_PULSE_SHORT_US = 10;
	localparam int BOOT_PULSE_LONG_MS = 1;
	localparam int ACQ_GAP_US = 40;
	localparam int BOOT_TIME_US = 100;
	// Times as cycle counts
	localparam int BOOT_PULSE_SHORT_CYC = BOOT_PULSE_SHORT_US * CLK_FREQ_MHZ;
	localparam int BOOT_PULSE_LONG_CYC = BOOT_PULSE_LONG_MS * 1000 * CLK_FREQ_MHZ;
	localparam int ACQ_GAP_CYC = ACQ_GAP_US * CLK_FREQ_MHZ;
	localparam int BOOT_TIME_CYC = BOOT_TIME_US * CLK_FREQ_MHZ;
endpackage : accel_regs_pkg

// file: vec_magnitude_calc.sv
// Sequential square root of the sum of three squared axis values
`timescale 1ns/1ns
module vec_magnitude_calc
	import accel_regs_pkg::*;
#(
	parameter int W = AXIS_BITS
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic start,
	input wire logic signed [W-1:0] ax,
	input wire logic signed [W-1:0] ay,
	input wire logic signed [W-1:0] az,
	output logic done,
	output logic [W-1:0] result
);
	localparam int SUM_W = 2 * W + 2;
	localparam int IDX_W = $clog2(W);

	// Root needs at least two bits to iterate
	if (W < 2) begin : g_bad_width
		$error("vec_magnitude_calc: W must be at least 2");
	end

	// Sign-extended copies so the products keep full width
	wire logic signed [2*W-1:0] ax_e = {{W{ax[W-1]}}, ax};
	wire logic signed [2*W-1:0] ay_e = {{W{ay[W-1]}}, ay};
	wire logic signed [2*W-1:0] az_e = {{W{az[W-1]}}, az};
	wire logic signed [2*W-1:0] sq_x = ax_e * ax_e;
	wire logic signed [2*W-1:0] sq_y = ay_e * ay_e;
	wire logic signed [2*W-1:0] sq_z = az_e * az_e;
	wire logic [SUM_W-1:0] sum_in = {2'b00, sq_x} + {2'b00, sq_y} + {2'b00, sq_z};

	logic [SUM_W-1:0] sum_r; // Held sum of squares
	logic [W-1:0] root_r; // Root built from the top bit down
	logic [IDX_W-1:0] idx_r; // Bit under trial
	logic busy_r; // Iteration in progress
	logic done_r; // One-cycle completion pulse

	// Trial root with the current bit set, and its square
	wire logic [W-1:0] trial = root_r | (W'(1) << idx_r);
	wire logic [2*W-1:0] trial_sq = {{W{1'b0}}, trial} * {{W{1'b0}}, trial};
	wire logic keep_bit = {2'b00, trial_sq} <= sum_r;

	// One result bit per cycle; floor of the true root, no rounding
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			sum_r <= '0;
			root_r <= '0;
			idx_r <= '0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else if (start) begin
			// A new start restarts any iteration in flight
			sum_r <= sum_in;
			root_r <= '0;
			idx_r <= IDX_W'(W - 1);
			busy_r <= 1'b1;
			done_r <= 1'b0;
		end else if (busy_r) begin
			root_r <= keep_bit ? trial : root_r;
			idx_r <= idx_r - IDX_W'(1);
			busy_r <= (idx_r != '0);
			done_r <= (idx_r == '0);
		end else begin
			done_r <= 1'b0;
		end
	end

	assign done = done_r;
	assign result = root_r;
endmodule : vec_magnitude_calc

// file: accel_output_data_regs.sv
// Output-data registers, boot pulse and sample latching of the motion sensor
`timescale 1ns/1ns
module accel_output_data_regs
	import accel_regs_pkg::*;
#(
	parameter int BOOT_LONG_CYCLES = BOOT_PULSE_LONG_CYC,
	parameter int BOOT_SHORT_CYCLES = BOOT_PULSE_SHORT_CYC,
	parameter int BOOT_RUN_CYCLES = BOOT_TIME_CYC,
	parameter int ACQ_GAP_CYCLES = ACQ_GAP_CYC
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic soft_rst,
	input wire logic hib_exit,
	input wire logic boot_signal_select_pin,
	input wire logic odr_tick,
	input wire logic [11:0] adc_data,
	output logic acq_strobe,
	output logic [1:0] acq_chan,
	input wire logic host_req,
	input wire logic host_wr,
	input wire logic host_first,
	input wire logic [7:0] host_addr,
	input wire logic [7:0] host_wdata,
	output logic host_ack,
	output logic host_nak,
	output logic [7:0] host_rdata,
	output logic boot_done_flag,
	output logic data_ready_flag,
	output logic first_interrupt_pin_out,
	output logic first_interrupt_pin_oe,
	output logic second_interrupt_pin_out,
	output logic second_interrupt_pin_oe
);
	// Counts must fit the shared counter and be at least one cycle
	if (BOOT_LONG_CYCLES < 1 || BOOT_LONG_CYCLES >= 2 ** CNT_W ||
		BOOT_SHORT_CYCLES < 1 || BOOT_SHORT_CYCLES >= 2 ** CNT_W ||
		BOOT_RUN_CYCLES < 1 || BOOT_RUN_CYCLES >= 2 ** CNT_W ||
		ACQ_GAP_CYCLES < 1 || ACQ_GAP_CYCLES >= 2 ** CNT_W) begin : g_bad_count
		$error("accel_output_data_regs: cycle count out of range");
	end

	typedef enum logic [1:0] {BOOT_RUN, BOOT_PULSE, BOOT_READY} boot_state_e;
	typedef enum logic [1:0] {ACQ_IDLE, ACQ_RUN, ACQ_START, ACQ_CALC} acq_state_e;

	localparam logic [CNT_W-1:0] LONG_LAST = CNT_W'(BOOT_LONG_CYCLES - 1);
	localparam logic [CNT_W-1:0] SHORT_LAST = CNT_W'(BOOT_SHORT_CYCLES - 1);
	localparam logic [CNT_W-1:0] RUN_LAST = CNT_W'(BOOT_RUN_CYCLES - 1);
	localparam logic [CNT_W-1:0] GAP_LAST = CNT_W'(ACQ_GAP_CYCLES - 1);

	// Places one 12-bit value into one byte of its register pair
	function automatic logic [7:0] pair_byte(input logic [11:0] v, input logic hi,
		input logic be, input logic fast, input logic sx);
		logic [3:0] ext;
		ext = {4{sx & v[11]}};
		if (fast && !hi) pair_byte = v[11:4];
		else if (be) pair_byte = hi ? {v[3:0], 4'h0} : v[11:4];
		else pair_byte = hi ? {ext, v[11:8]} : v[7:0];
	endfunction : pair_byte

	// Returns pin level and enable for a given active state and driver setup
	function automatic logic [1:0] pin_drive(input logic active, input logic pol,
		input logic od);
		logic level;
		// Polarity bit clear means active high, so the reset value gives a high pulse
		level = active ? ~pol : pol;
		// Open drain only pulls low; the high level comes from the pull-up
		pin_drive = od ? {1'b0, ~level} : {level, 1'b1};
	endfunction : pin_drive

	// Boot sequencer state
	boot_state_e boot_st_r;
	logic [CNT_W-1:0] boot_cnt_r; // Boot time, then pulse width
	logic long_mode_r; // Boot pin seen high at boot completion
	logic pulse_pol_r; // Polarity frozen for the pulse
	logic pulse_od_r; // Driver type frozen for the pulse
	logic pulse_route_r; // Pin mapping frozen for the pulse
	// Host-visible configuration
	logic [7:0] cfg_two_r; // Endian select and fast read
	logic [7:0] cfg_four_r; // Polarity and driver type, kept over soft reset
	logic [7:0] cfg_five_r; // Magnitude enable
	logic [7:0] pin_sel_r; // Boot pin mapping, kept over soft reset
	// Acquisition and output data
	acq_state_e acq_st_r;
	logic [CNT_W-1:0] gap_cnt_r; // Spacing between acquisitions
	logic [1:0] chan_r; // Channel being acquired
	logic strobe_r; // Acquisition request this cycle
	logic [11:0] shadow_r [0:3]; // Per-channel results before the latch
	logic [7:0] temperature_value_r;
	logic [11:0] axis_r [0:2]; // X, Y, Z output values
	logic [11:0] magnitude_r;
	logic data_ready_r;
	// Host port
	logic [7:0] ptr_r; // Burst address pointer
	logic ack_r;
	logic nak_r;
	logic [7:0] rdata_r;
	// Interrupt pins
	logic [1:0] pin1_r;
	logic [1:0] pin2_r;

	wire logic restart = soft_rst | hib_exit; // Both re-run the boot
	wire logic boot_done = (boot_st_r != BOOT_READY) ? (boot_st_r == BOOT_PULSE) : 1'b1;
	wire logic boot_finish = (boot_st_r == BOOT_RUN) && (boot_cnt_r == RUN_LAST);
	wire logic [CNT_W-1:0] pulse_last = long_mode_r ? LONG_LAST : SHORT_LAST;
	wire logic endian_be = cfg_two_r[CFG2_ENDIAN_BIT];
	wire logic fast_read = cfg_two_r[CFG2_FAST_READ_BIT];
	wire logic mag_en = cfg_five_r[CFG5_MAG_EN_BIT];

	// Host decode
	wire logic [7:0] acc_addr = host_first ? host_addr : ptr_r;
	wire logic take = host_req && boot_done && !restart;
	wire logic take_rd = take && !host_wr;
	wire logic take_wr = take && host_wr;
	wire logic clr_read = take_rd && (acc_addr >= ADDR_MAG_LOW) &&
		(acc_addr <= ADDR_Z_HIGH);
	wire logic axis_area = (acc_addr >= ADDR_X_LOW) && (acc_addr <= ADDR_Z_HIGH);
	wire logic [7:0] next_ptr = (fast_read && axis_area) ? acc_addr + 8'h02 :
		acc_addr + 8'h01;
	wire logic [2:0] axis_idx = 3'((acc_addr - ADDR_X_LOW) >> 1);
	wire logic axis_hi = acc_addr[0] ^ ADDR_X_LOW[0];
	wire logic [7:0] axis_byte = pair_byte(axis_r[axis_idx[1:0]], axis_hi, endian_be,
		fast_read, 1'b1);
	wire logic [7:0] mag_byte = pair_byte(magnitude_r, acc_addr == ADDR_MAG_HIGH,
		endian_be, 1'b0, 1'b0);
	// Widen before shifting so the flag bits are not shifted out of a one-bit value
	wire logic [7:0] status_byte = (8'(data_ready_r) << STATUS_DRDY_BIT) |
		(8'(boot_done) << STATUS_BOOT_BIT);

	// Read mux over the fixed address map
	wire logic [7:0] rd_byte =
		(acc_addr == ADDR_INT_STATUS) ? status_byte :
		(acc_addr == ADDR_TEMPERATURE) ? temperature_value_r :
		(acc_addr == ADDR_MAG_LOW || acc_addr == ADDR_MAG_HIGH) ? mag_byte :
		axis_area ? axis_byte :
		(acc_addr == ADDR_SENSOR_CONFIG_TWO) ? cfg_two_r :
		(acc_addr == ADDR_SENSOR_CONFIG_FOUR) ? cfg_four_r :
		(acc_addr == ADDR_SENSOR_CONFIG_FIVE) ? cfg_five_r :
		(acc_addr == ADDR_PIN_SELECT) ? pin_sel_r : UNMAPPED_READ;

	// Acquisition decode
	wire logic capture = (acq_st_r == ACQ_RUN) && strobe_r;
	wire logic next_chan = (acq_st_r == ACQ_RUN) && (gap_cnt_r == GAP_LAST) &&
		(chan_r != CHAN_Z);
	wire logic seq_start = (acq_st_r == ACQ_IDLE) && odr_tick && boot_done && !restart;
	wire logic mag_start = (acq_st_r == ACQ_START) && mag_en;
	wire logic mag_done;
	wire logic [11:0] mag_result;
	wire logic latch = ((acq_st_r == ACQ_START) && !mag_en) ||
		((acq_st_r == ACQ_CALC) && mag_done);

	vec_magnitude_calc #(.W(AXIS_BITS)) u_mag (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.start(mag_start),
		.ax(shadow_r[1]),
		.ay(shadow_r[2]),
		.az(shadow_r[3]),
		.done(mag_done),
		.result(mag_result)
	);

	// Boot sequencer: run time, then one pulse, then ready
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			boot_st_r <= BOOT_RUN;
			boot_cnt_r <= '0;
		end else if (restart) begin
			boot_st_r <= BOOT_RUN;
			boot_cnt_r <= '0;
		end else begin
			case (boot_st_r)
				BOOT_RUN: begin
					boot_st_r <= boot_finish ? BOOT_PULSE : BOOT_RUN;
					boot_cnt_r <= boot_finish ? '0 : boot_cnt_r + CNT_W'(1);
				end
				BOOT_PULSE: begin
					// Pulse length depends on the boot pin mode
					boot_st_r <= (boot_cnt_r == pulse_last) ? BOOT_READY : BOOT_PULSE;
					boot_cnt_r <= boot_cnt_r + CNT_W'(1);
				end
				BOOT_READY: boot_cnt_r <= '0;
				default: boot_st_r <= BOOT_RUN;
			endcase
		end
	end

	// Pulse setup frozen at completion so host writes cannot bend it
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			long_mode_r <= 1'b0;
			pulse_pol_r <= 1'b0;
			pulse_od_r <= 1'b0;
			pulse_route_r <= 1'b0;
		end else if (boot_finish && !restart) begin
			long_mode_r <= boot_signal_select_pin;
			pulse_pol_r <= cfg_four_r[CFG4_POLARITY_BIT];
			pulse_od_r <= cfg_four_r[CFG4_DRIVER_BIT];
			pulse_route_r <= pin_sel_r[PINSEL_BOOT_ROUTE_BIT];
		end
	end

	// Pin drive: quiet while booting, short pulse on the mapped pin, long pulse low on the second pin, idle after
	wire logic pulsing = (boot_st_r == BOOT_PULSE);
	wire logic cur_pol = cfg_four_r[CFG4_POLARITY_BIT];
	wire logic cur_od = cfg_four_r[CFG4_DRIVER_BIT];
	wire logic [1:0] pin1_nxt = (boot_st_r == BOOT_RUN) ? 2'h0 :
		pulsing ? pin_drive(!long_mode_r && !pulse_route_r, pulse_pol_r, pulse_od_r) :
		pin_drive(1'b0, cur_pol, cur_od);
	wire logic [1:0] pin2_nxt = (boot_st_r == BOOT_RUN) ? 2'h0 :
		(pulsing && long_mode_r) ? 2'h1 :
		pulsing ? pin_drive(pulse_route_r, pulse_pol_r, pulse_od_r) :
		pin_drive(1'b0, cur_pol, cur_od);
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pin1_r <= 2'h0;
			pin2_r <= 2'h0;
		end else begin
			pin1_r <= pin1_nxt;
			pin2_r <= pin2_nxt;
		end
	end

	// Configuration kept over soft reset; power-on and hibernate exit clear it
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cfg_four_r <= CFG_RESET;
			pin_sel_r <= CFG_RESET;
		end else if (hib_exit) begin
			cfg_four_r <= CFG_RESET;
			pin_sel_r <= CFG_RESET;
		end else if (take_wr) begin
			// Writes are only taken after boot, so the first short pulse is active high
			if (acc_addr == ADDR_SENSOR_CONFIG_FOUR) cfg_four_r <= host_wdata;
			if (acc_addr == ADDR_PIN_SELECT) pin_sel_r <= host_wdata;
		end
	end

	// Configuration cleared by every reset kind
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cfg_two_r <= CFG_RESET;
			cfg_five_r <= CFG_RESET;
		end else if (restart) begin
			cfg_two_r <= CFG_RESET;
			cfg_five_r <= CFG_RESET;
		end else if (take_wr) begin
			if (acc_addr == ADDR_SENSOR_CONFIG_TWO) cfg_two_r <= host_wdata;
			if (acc_addr == ADDR_SENSOR_CONFIG_FIVE) cfg_five_r <= host_wdata;
		end
	end

	// Acquisition sequencer: four channels spaced apart, then calculation
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			acq_st_r <= ACQ_IDLE;
			gap_cnt_r <= '0;
			chan_r <= CHAN_TEMP;
			strobe_r <= 1'b0;
		end else if (restart) begin
			acq_st_r <= ACQ_IDLE; // A reset drops a sample in flight
			strobe_r <= 1'b0;
		end else begin
			strobe_r <= seq_start || next_chan;
			case (acq_st_r)
				ACQ_IDLE: begin
					acq_st_r <= seq_start ? ACQ_RUN : ACQ_IDLE;
					chan_r <= CHAN_TEMP;
					gap_cnt_r <= '0;
				end
				ACQ_RUN: begin
					chan_r <= next_chan ? chan_r + 2'h1 : chan_r;
					gap_cnt_r <= next_chan ? '0 : gap_cnt_r + CNT_W'(1);
					// Last channel taken: move on to the shared latch
					acq_st_r <= (capture && chan_r == CHAN_Z) ? ACQ_START : ACQ_RUN;
				end
				ACQ_START: acq_st_r <= mag_en ? ACQ_CALC : ACQ_IDLE;
				ACQ_CALC: acq_st_r <= mag_done ? ACQ_IDLE : ACQ_CALC;
				default: acq_st_r <= ACQ_IDLE;
			endcase
		end
	end

	// Per-channel shadow values taken at each strobe
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < 4; i++) shadow_r[i] <= OUT_RESET;
		end else if (capture) begin
			shadow_r[chan_r] <= adc_data;
		end
	end

	// Output registers move together at the latch edge; a restart clears only the magnitude
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			temperature_value_r <= TEMP_RESET;
			for (int i = 0; i < 3; i++) axis_r[i] <= OUT_RESET;
			magnitude_r <= OUT_RESET;
		end else if (restart) begin
			magnitude_r <= OUT_RESET;
		end else if (latch) begin
			temperature_value_r <= shadow_r[0][7:0];
			for (int i = 0; i < 3; i++) axis_r[i] <= shadow_r[i + 1];
			if (acq_st_r == ACQ_CALC) magnitude_r <= mag_result;
		end
	end

	// Data-ready flag: a latch in the clearing cycle wins
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) data_ready_r <= 1'b0;
		else if (restart) data_ready_r <= 1'b0;
		else if (latch) data_ready_r <= 1'b1;
		else if (clr_read) data_ready_r <= 1'b0;
	end

	// Host answers one cycle after the request
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ack_r <= 1'b0;
			nak_r <= 1'b0;
			rdata_r <= 8'h00;
			ptr_r <= 8'h00;
		end else begin
			ack_r <= take;
			nak_r <= host_req && !take;
			if (take_rd) rdata_r <= rd_byte;
			if (take) ptr_r <= next_ptr;
		end
	end

	assign acq_strobe = strobe_r;
	assign acq_chan = chan_r;
	assign host_ack = ack_r;
	assign host_nak = nak_r;
	assign host_rdata = rdata_r;
	assign boot_done_flag = boot_done;
	assign data_ready_flag = data_ready_r;
	assign first_interrupt_pin_out = pin1_r[1];
	assign first_interrupt_pin_oe = pin1_r[0];
	assign second_interrupt_pin_out = pin2_r[1];
	assign second_interrupt_pin_oe = pin2_r[0];

	// Checks on the block's own outputs and internal state
	a_boot_refuse: assert property (@(posedge sys_clk) disable iff (!nrst)
		host_req && !boot_done |=> host_nak && !host_ack) else $error("access taken in boot");
	a_flag_stays: assert property (@(posedge sys_clk) disable iff (!nrst)
		boot_done && !restart |=> boot_done) else $error("boot flag dropped");
	a_latch_ready: assert property (@(posedge sys_clk) disable iff (!nrst)
		latch && !restart |=> data_ready_flag && axis_r[2] == $past(shadow_r[3]))
		else $error("latch without data ready");
	a_axis_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
		take_rd && axis_area && !latch |=> !data_ready_flag) else $error("axis read kept flag");
	a_mag_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
		take_rd && acc_addr == ADDR_MAG_HIGH && !latch |=> !data_ready_flag)
		else $error("magnitude read kept flag");
	a_sign_copy: assert property (@(posedge sys_clk) disable iff (!nrst)
		take_rd && acc_addr == ADDR_X_HIGH && !endian_be |=>
		host_rdata[7:4] == {4{axis_r[0][11]}}) else $error("sign copy wrong");
	a_big_nibble: assert property (@(posedge sys_clk) disable iff (!nrst)
		take_rd && acc_addr == ADDR_Y_HIGH && endian_be |=> host_rdata[3:0] == 4'h0)
		else $error("big endian low nibble not zero");
	a_fast_top: assert property (@(posedge sys_clk) disable iff (!nrst)
		take_rd && acc_addr == ADDR_Z_LOW && fast_read |=> host_rdata == axis_r[2][11:4])
		else $error("fast read byte wrong");
	a_fast_skip: assert property (@(posedge sys_clk) disable iff (!nrst)
		take && acc_addr == ADDR_X_LOW && fast_read |=> ptr_r == ADDR_Y_LOW)
		else $error("fast read did not skip");
	a_mag_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
		acq_st_r == ACQ_START && !mag_en && !restart |=> $stable(magnitude_r))
		else $error("magnitude changed while disabled");
	a_cfg_kept: assert property (@(posedge sys_clk) disable iff (!nrst)
		soft_rst && !hib_exit |=> $stable(cfg_four_r) && $stable(pin_sel_r))
		else $error("soft reset lost pin setup");
	a_long_pulse: assert property (@(posedge sys_clk) disable iff (!nrst)
		$rose(pulsing) && long_mode_r |=> second_interrupt_pin_oe && !second_interrupt_pin_out)
		else $error("long boot pulse not low");
	a_short_pulse: assert property (@(posedge sys_clk) disable iff (!nrst)
		$rose(pulsing) && !long_mode_r && !pulse_route_r && !pulse_pol_r && !pulse_od_r |=>
		first_interrupt_pin_out && first_interrupt_pin_oe)
		else $error("default boot pulse not high on first pin");
	a_gap_spacing: assert property (@(posedge sys_clk) disable iff (!nrst)
		strobe_r && chan_r != CHAN_Z && !restart |=> !strobe_r)
		else $error("acquisitions too close");
endmodule : accel_output_data_regs

// file: conv_model.sv
// Converter model answering the sequencer's acquisition strobes
`timescale 1ns/1ns
module conv_model (
	input wire logic sys_clk,
	input wire logic acq_strobe,
	input wire logic [1:0] acq_chan,
	input wire logic [11:0] t_val,
	input wire logic [11:0] x_val,
	input wire logic [11:0] y_val,
	input wire logic [11:0] z_val,
	output logic [11:0] adc_data
);
	logic [11:0] sel; // Value of the channel asked for
	assign sel = (acq_chan == 2'h0) ? t_val : (acq_chan == 2'h1) ? x_val :
		(acq_chan == 2'h2) ? y_val : z_val;
	// Outside a strobe show the inverse, so a late capture is caught
	assign adc_data = acq_strobe ? sel : ~sel;
endmodule : conv_model

// file: tb_accel_output_data_regs.sv
// Self-checking bench for the output-data registers
`timescale 1ns/1ns
module tb_accel_output_data_regs;
	import accel_regs_pkg::*;
	logic sys_clk = 0, nrst = 0, soft_rst = 0, hib_exit = 0, boot_signal_select_pin = 0;
	logic odr_tick = 0, host_req = 0, host_wr = 0, host_first = 0;
	logic [7:0] host_addr = 8'h00, host_wdata = 8'h00, host_rdata;
	logic [11:0] adc_data, tv, xv, yv, zv, mag; // Sample values and their magnitude
	logic acq_strobe, host_ack, host_nak, boot_done_flag, data_ready_flag;
	logic [1:0] acq_chan;
	logic [9:0] exp_q[$]; // Expected answers: {check data, nak, data}
	logic [9:0] e;
	logic [7:0] a;
	int fail_count = 0, n_compared = 0, seed = 32'ha97f26b4;
	int sq; // Signed sum of squares for the expected magnitude
	// Free-running 10 MHz clock
	initial begin
		forever #50 sys_clk = ~sys_clk;
	end
	accel_output_data_regs #(.BOOT_LONG_CYCLES(20), .BOOT_SHORT_CYCLES(4),
		.BOOT_RUN_CYCLES(8), .ACQ_GAP_CYCLES(5)) accel_output_data_regs_inst (
		.sys_clk(sys_clk), .nrst(nrst), .soft_rst(soft_rst), .hib_exit(hib_exit),
		.boot_signal_select_pin(boot_signal_select_pin), .odr_tick(odr_tick),
		.adc_data(adc_data), .acq_strobe(acq_strobe), .acq_chan(acq_chan),
		.host_req(host_req), .host_wr(host_wr), .host_first(host_first),
		.host_addr(host_addr), .host_wdata(host_wdata), .host_ack(host_ack),
		.host_nak(host_nak), .host_rdata(host_rdata), .boot_done_flag(boot_done_flag),
		.data_ready_flag(data_ready_flag), .first_interrupt_pin_out(),
		.first_interrupt_pin_oe(), .second_interrupt_pin_out(), .second_interrupt_pin_oe());
	conv_model conv_model_inst (.sys_clk(sys_clk), .acq_strobe(acq_strobe),
		.acq_chan(acq_chan), .t_val(tv), .x_val(xv), .y_val(yv), .z_val(zv),
		.adc_data(adc_data));
	// Verdict and end of run
	task print_verdict;
		if (fail_count == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : print_verdict
	// Single comparison point
	task check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// One host access; request stays up so back-to-back bursts work
	task host_op(input logic wr, input logic first, input logic [7:0] ad,
		input logic [7:0] wd, input logic [9:0] ex);
		host_req = 1;
		host_wr = wr;
		host_first = first;
		host_addr = ad;
		host_wdata = wd;
		exp_q.push_back(ex);
		@(posedge sys_clk) #1;
	endtask : host_op
	// Bounded wait on boot flag (0) or data-ready flag (1)
	task wait_flag(input int which);
		int k;
		for (k = 0; k < 500 && ((which == 0) ? boot_done_flag : data_ready_flag) !== 1; k++)
			@(posedge sys_clk) #1;
		if (k == 500) begin
			fail_count++;
			print_verdict();
		end
	endtask : wait_flag
	// Expected byte at an address for endian bit m[0] and fast read m[1]
	function automatic logic [7:0] exp_byte(input logic [7:0] ad, input logic [1:0] m);
		logic [11:0] v;
		v = (ad < 8'h04) ? mag : (ad < 8'h06) ? xv : (ad < 8'h08) ? yv : zv;
		if (ad == 8'h01) return tv[7:0];
		if (ad > 8'h09 || ad == 8'h00) return 8'h00;
		if (!ad[0] && (m[0] || (m[1] && ad >= 8'h04))) return v[11:4];
		if (!ad[0]) return v[7:0];
		if (m[0]) return {v[3:0], 4'h0};
		return {(ad >= 8'h04) ? {4{v[11]}} : 4'h0, v[11:8]};
	endfunction : exp_byte
	// Watcher: every answer takes the oldest note off the queue, mid-cycle where it is settled
	always @(negedge sys_clk) begin
		if (host_ack === 1'b1 || host_nak === 1'b1) begin
			if (exp_q.size() == 0) check(8'h01, 8'h00, "spare answer");
			else begin
				e = exp_q.pop_front();
				check({7'h0, host_nak}, {7'h0, e[8]}, "nak");
				if (e[9]) check(host_rdata, e[7:0], "rdata");
			end
		end
	end
	// Hang guard
	initial begin
		#9000000;
		fail_count++;
		print_verdict();
	end
	// Main sequence
	initial begin
		repeat (20) @(posedge sys_clk);
		#1 nrst = 1;
		host_op(0, 1, 8'h00, 8'h00, 10'h100);
		host_req = 0;
		wait_flag(0);
		host_op(0, 1, 8'h00, 8'h00, 10'h201);
		host_op(0, 1, 8'h40, 8'h00, 10'h200);
		host_op(1, 1, 8'h19, 8'h01, 10'h000);
		for (int m = 0; m < 4; m++) begin
			host_op(1, 1, 8'h16, 8'(m), 10'h000);
			host_req = 0;
			tv = 12'($random(seed));
			xv = 12'($random(seed));
			yv = 12'($random(seed));
			zv = 12'($random(seed));
			mag = 0;
			sq = $signed(xv) * $signed(xv) + $signed(yv) * $signed(yv) +
				$signed(zv) * $signed(zv);
			while ((mag + 1) * (mag + 1) <= sq) mag++;
			odr_tick = 1;
			@(posedge sys_clk) #1 odr_tick = 0;
			wait_flag(1);
			// Burst from the temperature byte; pointer skips axis high bytes in fast read
			a = 8'h01;
			for (int k = 0; a <= 8'h09; k++) begin
				host_op(0, k == 0, a, 8'h00, {2'b10, exp_byte(a, 2'(m))});
				a = a + ((m[1] && a >= 8'h04) ? 8'h02 : 8'h01);
			end
			host_req = 0;
			repeat (2) @(posedge sys_clk);
			#1 check({7'h0, data_ready_flag}, 8'h00, "ready flag");
		end
		// Soft reset in mid-run: pin setup kept, other config cleared
		host_op(1, 1, 8'h18, 8'h03, 10'h000);
		host_op(1, 1, 8'h19, 8'h01, 10'h000);
		host_req = 0;
		soft_rst = 1;
		@(posedge sys_clk) #1 soft_rst = 0;
		wait_flag(0);
		host_op(0, 1, 8'h18, 8'h00, 10'h203);
		host_op(0, 1, 8'h19, 8'h00, 10'h200);
		host_op(0, 1, 8'h00, 8'h00, 10'h201);
		host_req = 0;
		repeat (3) @(posedge sys_clk);
		print_verdict();
	end
endmodule : tb_accel_output_data_regs
